// ==== core/ppr_defines.svh ====
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH
// Return codes
`define PPR_RC_OK 8'h00
`define PPR_RC_CHANGE 8'h90
`define PPR_RC_LEN_SHORT 8'h91
`define PPR_RC_LEN_ZERO 8'h92
// Field positions
`define PPR_RSW_CHG_BIT 7
`define PPR_ST_JUMPER_BIT 7
`define PPR_ST_PARITY_BIT 2
`define PPR_VB_RSVD_MASK 7'h38
// Widths and reset values
`define PPR_LEN_W 24
`define PPR_RSW_RESET 16'h0000
// Timing
`define PPR_CLK_KHZ 20000
`define PPR_REFRESH_MS 30
`define PPR_REFRESH_CYC (`PPR_REFRESH_MS * `PPR_CLK_KHZ)
`endif

// ==== core/ppr_pkg.sv ====
package ppr_pkg;
  `include "ppr_defines.svh"

  // Print command fields
  typedef struct packed {
    logic [`PPR_LEN_W-1:0] bus_len;
    logic [`PPR_LEN_W-1:0] prn_count;
  } ppr_cmd_t;

  // Seven-word response block plus status snapshot
  typedef struct packed {
    logic [15:0] response_status_word;
    logic [4:0][15:0] rsvd;
    logic [15:0] err_word;
    logic [7:0] prn_status;
  } ppr_rsp_t;

  typedef enum logic [2:0] {
    PPR_IDLE = 3'b000,
    PPR_CHECK = 3'b001,
    PPR_FETCH = 3'b010,
    PPR_WAIT = 3'b011,
    PPR_SEND = 3'b100,
    PPR_DONE = 3'b101
  } ppr_state_t;
endpackage

// ==== core/ppr_status_snap.sv ====
`timescale 1ns/1ps
`include "ppr_defines.svh"
module ppr_status_snap (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic jumper_pin,
  input wire logic [6:0] line_pins,
  input wire logic chg_enable,
  input wire logic [6:0] line_int_en,
  output logic [7:0] status,
  output logic line_chg,
  output logic chg_evt
);
  import ppr_pkg::*;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prev;
    logic [1:0] fill;
    logic primed;
    logic line_chg;
    logic chg_evt;
  } ppr_snap_t;

  ppr_snap_t s_ff;
  ppr_snap_t nxt_s;
  logic [6:0] rise;
  logic [6:0] fall;
  logic [6:0] watch;

  // -------------------------------------------------
  // Synchronise pins and detect edges
  // -------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = {jumper_pin, line_pins};
    nxt_s.s2 = s_ff.s1;
    nxt_s.prev = s_ff.s2;
    // Edges count only once prev holds a synchronised sample, so none follows reset
    nxt_s.fill = {s_ff.fill[0], 1'b1};
    nxt_s.primed = s_ff.fill[1];
    rise = s_ff.s2[6:0] & ~s_ff.prev[6:0];
    fall = ~s_ff.s2[6:0] & s_ff.prev[6:0];
    // Variant B reserved lines never count as changes
    watch = s_ff.s2[`PPR_ST_JUMPER_BIT] ? 7'h7F : ~`PPR_VB_RSVD_MASK;
    // Parity error reports only its activation in variant A
    if (s_ff.s2[`PPR_ST_JUMPER_BIT]) begin
      fall[`PPR_ST_PARITY_BIT] = 1'b0;
    end
    nxt_s.line_chg = s_ff.primed && (((rise | fall) & watch) != 7'h00);
    nxt_s.chg_evt = s_ff.primed && chg_enable &&
                    (((rise | fall) & watch & line_int_en) != 7'h00);
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Bit 7 is the jumper, bits 6..0 the lines
  assign status = s_ff.s2;
  assign line_chg = s_ff.line_chg;
  assign chg_evt = s_ff.chg_evt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_jumper_bit: assert property (s_ff.primed |-> status[7] == $past(jumper_pin, 2))
    else $error("jumper bit not the synchronised jumper pin");
  a_parity_fall: assert property (s_ff.primed && status[7] && $fell(status[2])
      && $stable(status[6:3]) && $stable(status[1:0]) |=> !line_chg)
    else $error("parity deactivation reported in variant A");
  a_rsvd_ignored: assert property (s_ff.primed && !status[7] && $stable(status[7])
      && $stable({status[6], status[2:0]}) |=> !line_chg)
    else $error("reserved line change reported in variant B");
endmodule // ppr_status_snap

// ==== core/ppr_port.sv ====
`timescale 1ns/1ps
`include "ppr_defines.svh"
module ppr_port #(
  parameter int REFRESH_CYC = `PPR_REFRESH_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic jumper_pin,
  input wire logic [6:0] line_pins,
  input wire logic chg_enable,
  input wire logic [6:0] line_int_en,
  input wire logic cmd_valid,
  input wire ppr_pkg::ppr_cmd_t cmd,
  output logic cmd_ready,
  output logic dma_req_valid,
  output logic dma_req_long,
  output logic [`PPR_LEN_W-1:0] dma_req_offs,
  input wire logic dma_req_ready,
  input wire logic dma_rd_valid,
  input wire logic [31:0] dma_rd_data,
  output logic prn_valid,
  output logic [7:0] prn_byte,
  input wire logic prn_ready,
  output logic rsp_valid,
  output ppr_pkg::ppr_rsp_t rsp,
  input wire logic rsp_ready,
  output logic [7:0] shared_status
);
  import ppr_pkg::*;

  localparam logic [19:0] TICK_LAST = 20'(REFRESH_CYC - 1);

  typedef struct packed {
    ppr_state_t state;
    ppr_cmd_t cmd;
    logic [`PPR_LEN_W-1:0] bus_left;
    logic [`PPR_LEN_W-1:0] prn_left;
    logic [`PPR_LEN_W-1:0] offs;
    logic [31:0] buf_word;
    logic [2:0] buf_cnt;
    logic req_valid;
    logic req_long;
    logic [7:0] rc;
    ppr_rsp_t rsp;
    logic rsp_valid;
    logic chg_pend;
    logic [7:0] shared;
    logic [19:0] tick;
    logic prn_valid;
    logic [7:0] prn_byte;
  } ppr_port_st_t;

  ppr_port_st_t s_ff;
  ppr_port_st_t nxt_s;
  logic [7:0] st_now;
  logic line_chg;
  logic chg_evt;

  // -------------------------------------------------
  // Printer status lines
  // -------------------------------------------------
  ppr_status_snap u_snap (
    .clock(clock),
    .sys_rst(sys_rst),
    .jumper_pin(jumper_pin),
    .line_pins(line_pins),
    .chg_enable(chg_enable),
    .line_int_en(line_int_en),
    .status(st_now),
    .line_chg(line_chg),
    .chg_evt(chg_evt)
  );

  // Build one response block
  function automatic ppr_rsp_t mk_rsp(input logic chg, input logic [7:0] rc,
                                      input logic [7:0] st);
    ppr_rsp_t r;
    r = '0;
    r.response_status_word = `PPR_RSW_RESET;
    r.response_status_word[`PPR_RSW_CHG_BIT] = chg;
    r.err_word = {8'h00, rc};
    r.prn_status = st;
    return r;
  endfunction

  // -------------------------------------------------
  // Command sequencer and response poster
  // -------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // Handshakes retire
    if (s_ff.prn_valid && prn_ready) begin
      nxt_s.prn_valid = 1'b0;
    end
    if (s_ff.rsp_valid && rsp_ready) begin
      nxt_s.rsp_valid = 1'b0;
    end
    // Periodic refresh timer
    if (s_ff.tick >= TICK_LAST) begin
      nxt_s.tick = 20'h00000;
      nxt_s.shared = st_now;
    end else begin
      nxt_s.tick = s_ff.tick + 20'h00001;
    end
    // Refresh on any monitored line change
    if (line_chg) begin
      nxt_s.shared = st_now;
    end
    case (s_ff.state)
      PPR_IDLE: begin
        if (cmd_valid) begin
          nxt_s.cmd = cmd;
          nxt_s.state = PPR_CHECK;
        end
      end
      PPR_CHECK: begin
        nxt_s.bus_left = s_ff.cmd.bus_len;
        nxt_s.prn_left = s_ff.cmd.prn_count;
        nxt_s.offs = '0;
        nxt_s.buf_cnt = 3'h0;
        if (s_ff.cmd.bus_len == '0 && s_ff.cmd.prn_count == '0) begin
          nxt_s.rc = `PPR_RC_OK;
          nxt_s.state = PPR_DONE;
        end else if (s_ff.cmd.bus_len == '0) begin
          nxt_s.rc = `PPR_RC_LEN_ZERO;
          nxt_s.state = PPR_DONE;
        end else if (s_ff.cmd.bus_len < s_ff.cmd.prn_count) begin
          nxt_s.rc = `PPR_RC_LEN_SHORT;
          nxt_s.state = PPR_DONE;
        end else begin
          nxt_s.rc = `PPR_RC_OK;
          nxt_s.state = PPR_FETCH;
        end
      end
      PPR_FETCH: begin
        // No further word is fetched once the printer count is reached
        if (s_ff.prn_left == '0 || s_ff.bus_left == '0) begin
          if (!s_ff.prn_valid) begin
            nxt_s.state = PPR_DONE;
          end
        end else begin
          nxt_s.req_valid = 1'b1;
          nxt_s.req_long = (s_ff.bus_left >= `PPR_LEN_W'(4));
          nxt_s.state = PPR_WAIT;
        end
      end
      PPR_WAIT: begin
        if (s_ff.req_valid && dma_req_ready) begin
          nxt_s.req_valid = 1'b0;
        end
        if (!s_ff.req_valid && dma_rd_valid) begin
          // Big-endian lanes: first byte sits in the top lane, or in bits 15:8 for a two-byte fetch
          if (s_ff.req_long) begin
            nxt_s.buf_word = dma_rd_data;
            nxt_s.buf_cnt = 3'h4;
            nxt_s.bus_left = s_ff.bus_left - `PPR_LEN_W'(4);
            nxt_s.offs = s_ff.offs + `PPR_LEN_W'(4);
          end else begin
            nxt_s.buf_word = {dma_rd_data[15:0], 16'h0000};
            nxt_s.buf_cnt = 3'h2;
            nxt_s.bus_left = (s_ff.bus_left > `PPR_LEN_W'(2)) ?
                             s_ff.bus_left - `PPR_LEN_W'(2) : '0;
            nxt_s.offs = s_ff.offs + `PPR_LEN_W'(2);
          end
          nxt_s.state = PPR_SEND;
        end
      end
      PPR_SEND: begin
        if (!nxt_s.prn_valid) begin
          if (s_ff.buf_cnt != 3'h0 && s_ff.prn_left != '0) begin
            nxt_s.prn_byte = s_ff.buf_word[31:24];
            nxt_s.prn_valid = 1'b1;
            nxt_s.buf_word = {s_ff.buf_word[23:0], 8'h00};
            nxt_s.buf_cnt = s_ff.buf_cnt - 3'h1;
            nxt_s.prn_left = s_ff.prn_left - `PPR_LEN_W'(1);
          end else begin
            // Pad bytes left in the buffer are dropped
            nxt_s.buf_cnt = 3'h0;
            nxt_s.state = PPR_FETCH;
          end
        end
      end
      PPR_DONE: begin
        if (!nxt_s.rsp_valid) begin
          nxt_s.rsp = mk_rsp(1'b0, s_ff.rc, st_now);
          nxt_s.rsp_valid = 1'b1;
          nxt_s.shared = st_now;
          nxt_s.state = PPR_IDLE;
        end
      end
      default: begin
        nxt_s.state = PPR_IDLE;
      end
    endcase
    // Status-change block when the response slot is free
    if (s_ff.state != PPR_DONE && s_ff.chg_pend && !nxt_s.rsp_valid) begin
      nxt_s.rsp = mk_rsp(1'b1, `PPR_RC_CHANGE, st_now);
      nxt_s.rsp_valid = 1'b1;
      nxt_s.chg_pend = 1'b0;
    end
    // A new change wins over the clear
    if (chg_evt) begin
      nxt_s.chg_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign cmd_ready = (s_ff.state == PPR_IDLE);
  assign dma_req_valid = s_ff.req_valid;
  assign dma_req_long = s_ff.req_long;
  assign dma_req_offs = s_ff.offs;
  assign prn_valid = s_ff.prn_valid;
  assign prn_byte = s_ff.prn_byte;
  assign rsp_valid = s_ff.rsp_valid;
  assign rsp = s_ff.rsp;
  assign shared_status = s_ff.shared;

  // -------------------------------------------------
  // Checks
  // -------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_chk(logic c);
    s_ff.state == PPR_CHECK && c;
  endsequence
  sequence s_posted(logic [7:0] rc);
    s_ff.rsp_valid && s_ff.rsp.err_word[7:0] == rc &&
      !s_ff.rsp.response_status_word[`PPR_RSW_CHG_BIT];
  endsequence

  a_zero_status: assert property (s_chk(s_ff.cmd == '0) |-> ##[1:40] s_posted(8'h00))
    else $error("zero-length request not answered with status");
  a_zero_len: assert property (s_chk(s_ff.cmd.bus_len == '0 &&
      s_ff.cmd.prn_count != '0) |-> ##[1:40] s_posted(8'h92))
    else $error("zero bus length not rejected with 0x92");
  a_len_short: assert property (s_chk(s_ff.cmd.bus_len != '0 &&
      s_ff.cmd.bus_len < s_ff.cmd.prn_count) |-> ##[1:40] s_posted(8'h91))
    else $error("short bus length not rejected with 0x91");
  a_fetch_size: assert property ($rose(dma_req_valid) |->
      (dma_req_long == (s_ff.bus_left >= `PPR_LEN_W'(4))))
    else $error("fetch size does not follow remaining length");
  a_chg_code: assert property (s_ff.rsp_valid &&
      s_ff.rsp.response_status_word[`PPR_RSW_CHG_BIT] |->
      s_ff.rsp.err_word == 16'h0090)
    else $error("status-change block has wrong code word");
  a_chg_posted: assert property (chg_evt && !s_ff.rsp_valid &&
      s_ff.state == PPR_IDLE && !cmd_valid |=> ##1 s_ff.rsp_valid &&
      s_ff.rsp.response_status_word[`PPR_RSW_CHG_BIT])
    else $error("enabled status change not posted");
  a_snapshot: assert property ($rose(s_ff.rsp_valid) |->
      s_ff.rsp.prn_status == $past(st_now))
    else $error("response snapshot differs from status lines");
  a_refresh: assert property (line_chg |=> shared_status == $past(st_now))
    else $error("shared status not refreshed on line change");

  // Handshake outputs stand until taken
  a_req_hold: assert property (dma_req_valid && !dma_req_ready |=> dma_req_valid &&
      $stable(dma_req_offs) && $stable(dma_req_long))
    else $error("fetch request dropped or changed before acceptance");
  a_byte_hold: assert property (prn_valid && !prn_ready |=>
      prn_valid && $stable(prn_byte))
    else $error("printer byte dropped or changed before acceptance");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response block dropped or changed before acceptance");
  // Fetches start on even offsets; the period timer rewrites the shared byte
  a_fetch_align: assert property (dma_req_valid |-> !dma_req_offs[0])
    else $error("fetch offset not word aligned");
  a_tick_refresh: assert property (s_ff.tick >= TICK_LAST |=>
      shared_status == $past(st_now))
    else $error("shared status not refreshed by the period timer");
endmodule // ppr_port

// ==== tb/ppr_printer_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Printer side: takes bytes, may stall
// ----------------------------------------
module ppr_printer_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic prn_valid,
  input wire logic [7:0] prn_byte,
  output logic prn_ready
);
  logic [7:0] mem [0:31];
  int cnt;
  // Store on a sampled handshake; slow mode drops ready every other cycle
  always @(posedge clock) begin
    if (sys_rst) begin
      prn_ready <= 1'b0;
      cnt <= 0;
    end else begin
      if (prn_valid && prn_ready) begin
        mem[cnt] <= prn_byte;
        cnt <= cnt + 1;
      end
      prn_ready <= slow ? !prn_ready : 1'b1;
    end
  end
endmodule // ppr_printer_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import ppr_pkg::*;
  logic clock, sys_rst, jumper_pin, chg_enable, cmd_valid, cmd_ready, slow;
  logic dma_req_valid, dma_req_long, dma_req_ready, dma_rd_valid;
  logic prn_valid, prn_ready, rsp_valid, rsp_ready;
  logic [6:0] line_pins, line_int_en;
  logic [23:0] dma_req_offs;
  logic [31:0] dma_rd_data;
  logic [7:0] prn_byte, shared_status;
  ppr_cmd_t cmd;
  ppr_rsp_t rsp;
  int fails, total_checks, cyc, base;

  ppr_port #(.REFRESH_CYC(50)) ppr_port_i (.clock(clock), .sys_rst(sys_rst),
    .jumper_pin(jumper_pin), .line_pins(line_pins), .chg_enable(chg_enable),
    .line_int_en(line_int_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .dma_req_valid(dma_req_valid), .dma_req_long(dma_req_long),
    .dma_req_offs(dma_req_offs), .dma_req_ready(dma_req_ready),
    .dma_rd_valid(dma_rd_valid), .dma_rd_data(dma_rd_data), .prn_valid(prn_valid),
    .prn_byte(prn_byte), .prn_ready(prn_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_ready(rsp_ready), .shared_status(shared_status));

  ppr_printer_model ppr_printer_model_i (.clock(clock), .sys_rst(sys_rst), .slow(slow),
    .prn_valid(prn_valid), .prn_byte(prn_byte), .prn_ready(prn_ready));

  // ----------------------------------------
  // Clock, memory side and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [7:0] pat(input logic [23:0] o);
    return 8'hA0 + o[7:0];
  endfunction

  // Grant a fetch, return its data next cycle; data scrambles outside valid
  always @(posedge clock) begin
    dma_rd_valid <= 1'b0;
    dma_rd_data <= ~dma_rd_data;
    if (dma_req_ready) begin
      dma_req_ready <= 1'b0;
      dma_rd_valid <= 1'b1;
      if (dma_req_long) begin
        dma_rd_data <= {pat(dma_req_offs), pat(dma_req_offs + 24'h1),
                        pat(dma_req_offs + 24'h2), pat(dma_req_offs + 24'h3)};
      end else begin
        dma_rd_data <= {16'h0000, pat(dma_req_offs), pat(dma_req_offs + 24'h1)};
      end
    end else if (dma_req_valid) begin
      dma_req_ready <= 1'b1;
    end
  end

  // Cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [120:0] got, input logic [120:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [23:0] bl, input logic [23:0] pc);
    cmd_valid <= 1'b1;
    cmd <= '{bus_len: bl, prn_count: pc};
    do begin
      @(posedge clock);
    end while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask

  // Wait for a block, compare every field with the status byte masked by m, then take it
  task automatic get_rsp(input logic [7:0] code, input logic chg, input logic [7:0] st,
                         input logic [7:0] m);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    chk({rsp_valid, rsp.response_status_word, rsp.rsvd, rsp.err_word, rsp.prn_status & m},
        {1'b1, chg ? 16'h0080 : 16'h0000, 80'h0, 8'h00, code, st & m});
    rsp_ready <= 1'b1;
    @(posedge clock);
    rsp_ready <= 1'b0;
  endtask

  task automatic no_rsp(input int n);
    repeat (n) begin
      @(posedge clock);
      chk(rsp_valid, 1'b0);
    end
  endtask

  task automatic chk_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      chk(ppr_printer_model_i.mem[base + i], pat(i));
    end
    chk(ppr_printer_model_i.cnt, base + n);
    base = base + n;
  endtask

  task stop_test;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {sys_rst, jumper_pin} = 2'b11;
    {chg_enable, cmd_valid, slow, rsp_ready, dma_req_ready, dma_rd_valid} = '0;
    {line_pins, line_int_en, dma_rd_data, cmd} = {7'h0B, 7'h7F, 32'h0, 48'h0};
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    chk({cmd_ready, rsp_valid}, 2'b10);
    repeat (5) @(posedge clock);
    send(0, 0);
    get_rsp(8'h00, 1'b0, 8'h8B, 8'hFF);
    chk(shared_status, 8'h8B);
    send(2, 3);
    get_rsp(8'h91, 1'b0, 8'h8B, 8'hFF);
    send(0, 1);
    get_rsp(8'h92, 1'b0, 8'h8B, 8'hFF);
    send(4, 3);
    get_rsp(8'h00, 1'b0, 8'h8B, 8'hFF);
    chk_bytes(3);
    slow <= 1'b1;
    send(6, 5);
    get_rsp(8'h00, 1'b0, 8'h8B, 8'hFF);
    chk_bytes(5);
    line_pins <= 7'h0A;
    no_rsp(15);
    chk(shared_status, 8'h8A);
    chg_enable <= 1'b1;
    @(posedge clock);
    line_pins <= 7'h4A;
    get_rsp(8'h90, 1'b1, 8'hCA, 8'hFF);
    line_pins <= 7'h43;
    get_rsp(8'h90, 1'b1, 8'hC3, 8'hFF);
    no_rsp(10);
    line_pins <= 7'h47;
    get_rsp(8'h90, 1'b1, 8'hC7, 8'hFF);
    line_pins <= 7'h43;
    no_rsp(15);
    line_int_en <= 7'h7E;
    line_pins <= 7'h42;
    no_rsp(15);
    jumper_pin <= 1'b0;
    line_int_en <= 7'h7F;
    repeat (5) @(posedge clock);
    send(0, 0);
    get_rsp(8'h00, 1'b0, 8'h42, 8'hC7);
    line_pins <= 7'h52;
    no_rsp(15);
    line_pins <= 7'h56;
    get_rsp(8'h90, 1'b1, 8'h56, 8'hC7);
    stop_test();
  end
endmodule // tb_top
